// ### hdl/hwc_params.svh
// Constants for the halt wake-up controller
`ifndef HWC_PARAMS_SVH
`define HWC_PARAMS_SVH
`define HWC_PRIO_W 2
`define HWC_LEVEL3 2'h3
`define HWC_CLK_RESTART_CYC 2'h1
`define HWC_BUSY_RST 1'b0
`endif

// ### hdl/hwc_pkg.sv
// Types for the halt wake-up controller
`include "hwc_params.svh"
package hwc_pkg;
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_HALT = 3'h1,
      ST_CLKUP = 3'h2,
      ST_MACRO = 3'h3,
      ST_RESUME = 3'h4
   } hwc_state_t;
   typedef enum logic [1:0] {
      WK_NONE = 2'h0,
      WK_NMI = 2'h1,
      WK_MASKABLE = 2'h2
   } hwc_wake_t;
   // Maskable request as presented by the interrupt controller
   typedef struct packed {
      logic req;
      logic sourceMaskBit;
      logic isMacro;
      logic [`HWC_PRIO_W-1:0] prio;
   } hwc_mreq_t;
   // What the core is servicing right now
   typedef struct packed {
      logic inService;
      logic [`HWC_PRIO_W-1:0] svcPrio;
      logic nmiSameInService;
      logic nmiHigherInService;
   } hwc_svc_t;
   // Commands to the core
   typedef struct packed {
      logic cpuClkEn;
      logic takeNmi;
      logic takeMaskable;
      logic resumeNext;
      logic macroStart;
      logic nmiPending;
      logic maskPending;
   } hwc_cmd_t;
endpackage

// ### hdl/hwc_ack_judge.sv
// Acknowledge decision for a waking request
`timescale 1ns/1ps
`include "hwc_params.svh"
module hwc_ack_judge (
   // Request
   input wire hwc_pkg::hwc_wake_t wakeKind,
   input wire logic [`HWC_PRIO_W-1:0] reqPrio,
   // Core state
   input wire hwc_pkg::hwc_svc_t svc,
   input wire logic globalIrqEnableFlag,
   input wire logic level3PrioritySelect,
   // Decision
   output logic canAck
);
   always_comb begin
      canAck = 1'b0;
      unique case (wakeKind)
         // NMI blocked by same or higher NMI
         hwc_pkg::WK_NMI: canAck = !(svc.nmiSameInService || svc.nmiHigherInService);
         hwc_pkg::WK_MASKABLE: begin
            if (globalIrqEnableFlag) begin
               if (!svc.inService) begin
                  canAck = 1'b1;
               end else if (reqPrio < svc.svcPrio) begin
                  canAck = 1'b1;
               end else if (svc.svcPrio == `HWC_LEVEL3 && !level3PrioritySelect) begin
                  canAck = 1'b1;
               end
            end
         end
         default: canAck = 1'b0;
      endcase
   end
endmodule

// ### hdl/hwc_halt_wakeup.sv
// Halt wake-up sequencing between interrupt controller and core
`timescale 1ns/1ps
`include "hwc_params.svh"
// Functional notes
// - Only NMI, maskable request or reset end HALT; reset does normal reset.
// - Only the NMI pin may wake as non-maskable.
// - Vectored, context switch and macro service requests are maskable wakes.
// - Acknowledge pin NMI unless same or higher NMI routine runs.
// - Unacknowledged NMI resumes after halt write and stays pending.
// - Enabled unmasked maskable acknowledged: idle, lower routine, or level 3 exception.
// - Same or higher routine: resume after halt write, request pending.
// - Mask bit 1 keeps HALT for maskable and macro requests.
// - Unmasked macro request runs transfer; not ended returns to HALT.
// - Macro end: suppress bit 1 re-halts, 0 acts as maskable wake.
// - Enable condition is the status word enable flag.
// - Pending wake request acknowledged once acknowledgement is possible.
// - Enable flag 0 wake resumes after halt write, no branch.
// - Watchdog events never end HALT.
// - NMI pin wakes regardless of enable flag.
module hwc_halt_wakeup (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Halt entry from standby control write
   input wire logic haltEnter,
   // Wake sources
   input wire logic nmiPin,
   input wire logic nmiOther,
   input wire logic watchdogEvent,
   input wire hwc_pkg::hwc_mreq_t mreq,
   // Core and interrupt controller state
   input wire hwc_pkg::hwc_svc_t svc,
   input wire logic globalIrqEnableFlag,
   input wire logic level3PrioritySelect,
   input wire logic endIrqSuppressBit,
   input wire logic macroDone,
   input wire logic macroEndMet,
   input wire logic pendingTaken,
   // Outputs to core
   output hwc_pkg::hwc_cmd_t cmd,
   output logic halted
);
   typedef struct packed {
      hwc_pkg::hwc_state_t st;
      hwc_pkg::hwc_wake_t kind;
      logic [`HWC_PRIO_W-1:0] prio;
      logic [1:0] cnt;
      hwc_pkg::hwc_cmd_t cmd;
      logic halted;
   } hwc_reg_t;

   hwc_reg_t state_r;
   hwc_reg_t state_nxt;
   logic canAck;
   logic wakeSel;

   ////////////////////////////////////////////////////////////////////////
   // Judge acknowledge on registered kind, or on a pending request
   hwc_ack_judge u_hwc_ack_judge (
      .wakeKind(wakeSel ? state_r.kind
                : (state_r.cmd.nmiPending ? hwc_pkg::WK_NMI : hwc_pkg::WK_MASKABLE)),
      .reqPrio(state_r.prio),
      .svc(svc),
      .globalIrqEnableFlag(globalIrqEnableFlag),
      .level3PrioritySelect(level3PrioritySelect),
      .canAck(canAck)
   );
   assign wakeSel = (state_r.st == hwc_pkg::ST_RESUME);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      state_nxt.cmd.takeNmi = 1'b0;
      state_nxt.cmd.takeMaskable = 1'b0;
      state_nxt.cmd.resumeNext = 1'b0;
      state_nxt.cmd.macroStart = 1'b0;
      unique case (state_r.st)
         hwc_pkg::ST_RUN: begin
            // Pending taken once acknowledgeable
            // No branch in the cycle the clock is being stopped
            if ((state_r.cmd.nmiPending || state_r.cmd.maskPending) && canAck
                  && !haltEnter) begin
               state_nxt.cmd.takeNmi = state_r.cmd.nmiPending;
               state_nxt.cmd.takeMaskable = !state_r.cmd.nmiPending;
            end
            // Core take report clears both pending flags
            if (pendingTaken) begin
               state_nxt.cmd.nmiPending = 1'b0;
               state_nxt.cmd.maskPending = 1'b0;
            end
            if (haltEnter) begin
               state_nxt.st = hwc_pkg::ST_HALT;
               state_nxt.cmd.cpuClkEn = 1'b0;
               state_nxt.halted = 1'b1;
            end
         end
         hwc_pkg::ST_HALT: begin
            if (nmiPin) begin
               state_nxt.kind = hwc_pkg::WK_NMI;
               state_nxt.st = hwc_pkg::ST_CLKUP;
               state_nxt.cnt = `HWC_CLK_RESTART_CYC;
               state_nxt.cmd.cpuClkEn = 1'b1;
            end else if (mreq.req && !mreq.sourceMaskBit) begin
               state_nxt.kind = hwc_pkg::WK_MASKABLE;
               state_nxt.prio = mreq.prio;
               // Macro transfer runs without the CPU clock
               if (mreq.isMacro) begin
                  state_nxt.st = hwc_pkg::ST_MACRO;
                  state_nxt.cmd.macroStart = 1'b1;
               end else begin
                  state_nxt.st = hwc_pkg::ST_CLKUP;
                  state_nxt.cnt = `HWC_CLK_RESTART_CYC;
                  state_nxt.cmd.cpuClkEn = 1'b1;
               end
            end
         end
         hwc_pkg::ST_MACRO: begin
            if (macroDone) begin
               // Suppressed end or no end goes back to HALT
               if (macroEndMet && !endIrqSuppressBit) begin
                  state_nxt.st = hwc_pkg::ST_CLKUP;
                  state_nxt.cnt = `HWC_CLK_RESTART_CYC;
                  state_nxt.cmd.cpuClkEn = 1'b1;
               end else begin
                  state_nxt.st = hwc_pkg::ST_HALT;
               end
            end
         end
         hwc_pkg::ST_CLKUP: begin
            // Clock runs before the core moves
            if (state_r.cnt == 2'h0) begin
               state_nxt.st = hwc_pkg::ST_RESUME;
            end else begin
               state_nxt.cnt = state_r.cnt - 2'h1;
            end
         end
         hwc_pkg::ST_RESUME: begin
            state_nxt.st = hwc_pkg::ST_RUN;
            state_nxt.halted = 1'b0;
            if (canAck) begin
               state_nxt.cmd.takeNmi = (state_r.kind == hwc_pkg::WK_NMI);
               state_nxt.cmd.takeMaskable = (state_r.kind == hwc_pkg::WK_MASKABLE);
            end else begin
               state_nxt.cmd.resumeNext = 1'b1;
               if (state_r.kind == hwc_pkg::WK_NMI) begin
                  state_nxt.cmd.nmiPending = 1'b1;
               end else begin
                  state_nxt.cmd.maskPending = 1'b1;
               end
            end
         end
         default: state_nxt.st = hwc_pkg::ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset aborts HALT into normal reset state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= '0;
         state_r.cmd.cpuClkEn <= 1'b1;
         state_r.halted <= `HWC_BUSY_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cmd = state_r.cmd;
   assign halted = state_r.halted;
endmodule

// ### tb/hwc_core_model.sv
// Core stand-in: macro transfers and pending takes
`timescale 1ns/1ps
module hwc_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link
   input wire hwc_pkg::hwc_cmd_t cmd,
   input wire logic endMet,
   output logic macroDone,
   output logic macroEndMet,
   output logic pendingTaken
);
   int cnt;
   // Fixed transfer length; never aborted
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         macroDone <= 1'b0;
         pendingTaken <= 1'b0;
      end else begin
         macroDone <= (cnt == 1);
         cnt <= cmd.macroStart ? 2 : (cnt > 0 ? cnt - 1 : 0);
         pendingTaken <= cmd.takeNmi | cmd.takeMaskable;
      end
   end
   // Meaningless outside the pulse, so inverted there
   assign macroEndMet = macroDone ? endMet : !endMet;
endmodule

// ### tb/hwc_halt_wakeup_monitor.sv
// Port assertions for the halt wake-up controller
`timescale 1ns/1ps
module hwc_halt_wakeup_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Inputs
   input wire logic haltEnter,
   input wire logic nmiPin,
   input wire hwc_pkg::hwc_mreq_t mreq,
   input wire logic globalIrqEnableFlag,
   input wire logic endIrqSuppressBit,
   input wire logic macroDone,
   input wire logic macroEndMet,
   // Outputs
   input wire hwc_pkg::hwc_cmd_t cmd,
   input wire logic halted
);
   logic inMac_r;
   logic idle;
   logic mw;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Macro in flight is not plain HALT
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) inMac_r <= 1'b0;
      else if (cmd.macroStart) inMac_r <= 1'b1;
      else if (macroDone) inMac_r <= 1'b0;
   end
   assign idle = halted && !cmd.cpuClkEn && !inMac_r && !cmd.macroStart;
   assign mw = idle && !nmiPin && mreq.req && !mreq.sourceMaskBit;
   a_no_stray_wake: assert property (idle && !nmiPin && !mw |=> halted && !cmd.cpuClkEn)
      else $error("stray wake");
   a_nmi_clk_up: assert property (idle && nmiPin |=> cmd.cpuClkEn)
      else $error("nmi clock");
   a_nmi_answer: assert property (idle && nmiPin |-> ##4 cmd.takeNmi ^ cmd.resumeNext)
      else $error("nmi answer");
   a_ie_off_resume: assert property (mw && !mreq.isMacro && !globalIrqEnableFlag |-> ##4
      cmd.resumeNext && cmd.maskPending)
      else $error("ie off");
   a_macro_go: assert property (mw && mreq.isMacro |=> cmd.macroStart)
      else $error("macro start");
   a_macro_rehalt: assert property (inMac_r && macroDone && !(macroEndMet &&
      !endIrqSuppressBit) |=> halted [*3])
      else $error("macro rehalt");
   a_macro_wake: assert property (inMac_r && macroDone && macroEndMet &&
      !endIrqSuppressBit |=> cmd.cpuClkEn)
      else $error("macro wake");
   a_clk_first: assert property (cmd.takeNmi || cmd.takeMaskable || cmd.resumeNext
      |-> cmd.cpuClkEn)
      else $error("clock off");
   a_halt_stop: assert property (haltEnter && !halted && cmd.cpuClkEn |-> ##[1:4]
      (halted && !cmd.cpuClkEn))
      else $error("halt entry");
endmodule
bind hwc_halt_wakeup hwc_halt_wakeup_monitor u_mon (.core_clk, .rst, .haltEnter, .nmiPin,
   .mreq, .globalIrqEnableFlag, .endIrqSuppressBit, .macroDone, .macroEndMet, .cmd, .halted);

// ### tb/tb_hwc_halt_wakeup.sv
// Self-checking bench for the halt wake-up controller
`timescale 1ns/1ps
module tb_hwc_halt_wakeup;
   logic core_clk, rst, haltEnter, nmiPin, nmiOther, watchdogEvent, endMet;
   logic globalIrqEnableFlag, level3PrioritySelect, endIrqSuppressBit;
   logic macroDone, macroEndMet, pendingTaken, halted;
   hwc_pkg::hwc_mreq_t mreq;
   hwc_pkg::hwc_svc_t svc;
   hwc_pkg::hwc_cmd_t cmd;
   int failures, checks_done;
   // {svc, level 3 select, request prio, acknowledged}: idle, lower, same, higher, level 3
   logic [8:0] tbl [6] = '{9'h003, 9'h183, 9'h142, 9'h102, 9'h1C7, 9'h1CE};
   wire logic [7:0] obs = {halted, cmd};
   hwc_halt_wakeup u_hwc_halt_wakeup (.core_clk, .rst, .haltEnter, .nmiPin, .nmiOther,
      .watchdogEvent, .mreq, .svc, .globalIrqEnableFlag, .level3PrioritySelect,
      .endIrqSuppressBit, .macroDone, .macroEndMet, .pendingTaken, .cmd, .halted);
   hwc_core_model u_hwc_core_model (.core_clk, .rst, .cmd, .endMet, .macroDone,
      .macroEndMet, .pendingTaken);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // One-cycle wake pulse; returns while the answer pulse stands
   task automatic wk(input logic n, input logic [4:0] r);
      nmiPin = n;
      mreq = r;
      @(negedge core_clk);
      nmiPin = 1'b0;
      mreq = '0;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic hlt;
      haltEnter = 1'b1;
      @(negedge core_clk);
      haltEnter = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("halt", obs, 8'h80);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      failures++;
      report_and_stop();
   end
   initial begin
      {rst, haltEnter, nmiPin, nmiOther, watchdogEvent, endMet} = 6'h20;
      {globalIrqEnableFlag, level3PrioritySelect, endIrqSuppressBit} = 3'h0;
      mreq = '0;
      svc = '0;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      chk("reset", obs, 8'h40);
      hlt();
      {nmiOther, watchdogEvent} = 2'h3;
      wk(1'b0, 5'h19);
      chk("ignored", obs, 8'h80);
      wk(1'b0, 5'h1D);
      {nmiOther, watchdogEvent} = 2'h0;
      chk("macro masked", obs, 8'h80);
      wk(1'b1, 5'h00);
      chk("nmi take", obs, 8'h60);
      for (int i = 0; i < 2; i++) begin
         svc = 5'h01 << i;
         hlt();
         wk(1'b1, 5'h00);
         chk("nmi held", obs, 8'h4A);
         svc = '0;
         repeat (8) @(negedge core_clk);
         chk("nmi pend", obs, 8'h40);
      end
      hlt();
      wk(1'b0, 5'h11);
      chk("ie off", obs, 8'h49);
      globalIrqEnableFlag = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("ie on", obs, 8'h40);
      foreach (tbl[i]) begin
         svc = tbl[i][8:4];
         level3PrioritySelect = tbl[i][3];
         hlt();
         wk(1'b0, {3'h4, tbl[i][2:1]});
         chk("mask wake", obs, tbl[i][0] ? 8'h50 : 8'h49);
         svc = '0;
         repeat (8) @(negedge core_clk);
         chk("mask pend", obs, 8'h40);
      end
      for (int i = 0; i < 3; i++) begin
         endMet = (i > 0);
         endIrqSuppressBit = (i < 2);
         hlt();
         wk(1'b0, 5'h15);
         repeat (8) @(negedge core_clk);
         chk("macro", obs, (i == 2) ? 8'h40 : 8'h80);
      end
      hlt();
      rst = 1'b1;
      @(negedge core_clk);
      chk("reset halt", obs, 8'h40);
      rst = 1'b0;
      @(negedge core_clk);
      report_and_stop();
   end
endmodule
